/* hw/tcc_pkg.sv */
// Shared constants and types of the two-channel capture/compare block.
// Assumes an 8-bit register port on one 50 MHz clock, reset_n synchronous.
`default_nettype none

package tcc_pkg;

    // ********************************************************
    // Widths and register offsets
    // ********************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CNT_W = 16;
    localparam int NUM_CH = 2;

    typedef logic [ADDR_W-1:0] tcc_addr_t;
    typedef logic [DATA_W-1:0] tcc_byte_t;
    typedef logic [CNT_W-1:0] tcc_word_t;

    localparam tcc_addr_t OFF_CTL = 8'h40;
    localparam tcc_addr_t OFF_SC0 = 8'h45;
    localparam tcc_addr_t OFF_VAL0_HI = 8'h46;
    localparam tcc_addr_t OFF_VAL0_LO = 8'h47;
    localparam tcc_addr_t OFF_SC1 = 8'h48;
    localparam tcc_addr_t OFF_VAL1_HI = 8'h49;
    localparam tcc_addr_t OFF_VAL1_LO = 8'h4A;

    // ********************************************************
    // Field positions of the channel status/control byte and the control register
    // ********************************************************
    localparam int SC_FLAG_BIT = 7;
    localparam int CTL_HALT_BIT = 5;
    localparam int CTL_CLEAR_BIT = 4;

    // Edge/level codes
    localparam logic [1:0] ELS_OFF = 2'h0;
    localparam logic [1:0] ELS_TOGGLE = 2'h1;
    localparam logic [1:0] ELS_CLEAR = 2'h2;
    localparam logic [1:0] ELS_SET = 2'h3;

    // Reset values
    localparam tcc_byte_t ZERO_BYTE = 8'h00;
    localparam logic HALT_RESET = 1'b1;

    // Configuration bits below the flag, in register bit order 6..0
    typedef struct packed {
        logic irq_enable;
        logic buffered_mode_select;
        logic mode_select_a;
        logic [1:0] edge_level_sel;
        logic toggle_on_overflow;
        logic max_duty_force;
    } tcc_chan_cfg_t;

    localparam tcc_chan_cfg_t CFG_RESET = '0;

endpackage

`default_nettype wire

/* hw/tcc_value_store.sv */
// Value store: the two 16-bit channel value registers.
// Assumes the caller never asserts a capture and a bus write together.
`default_nettype none

module tcc_value_store
    import tcc_pkg::*;
(
    input wire logic clk,
    input wire logic [1:0] wr_hi,
    input wire logic [1:0] wr_lo,
    input wire tcc_pkg::tcc_byte_t wdata,
    input wire logic [1:0] cap_en,
    input wire tcc_pkg::tcc_word_t cap_data,
    output tcc_pkg::tcc_word_t value_ff [2]
);

    // ********************************************************
    // Storage
    // ********************************************************
    // No reset: contents are undefined until software or a capture loads them
    for (genvar gi = 0; gi < NUM_CH; gi++) begin : g_word
        always_ff @(posedge clk) begin
            if (cap_en[gi]) begin
                value_ff[gi] <= cap_data;
            end else if (wr_hi[gi]) begin
                value_ff[gi][CNT_W-1:DATA_W] <= wdata;
            end else if (wr_lo[gi]) begin
                value_ff[gi][DATA_W-1:0] <= wdata;
            end
        end
    end

endmodule

`default_nettype wire

/* hw/tcc_capture_compare.sv */
// Two-channel capture/compare/PWM logic of a 16-bit timer.
// Assumes counter value and overflow pulse come from logic on clk.
// Operation
// - Flag sets on capture edge or match
// - Flag clears by read-set then write zero
// - Reset clears flag and all config bits
// - Enable bit gates channel interrupt requests
// - Buffered mode: set, clear, toggle on compare
// - Buffered bit in channel 0 disables channel 1
// - Mode bit A picks capture or compare
// - Edge field zero: bit A presets level
// - Edge field zero leaves pin to port
// - Capture edges: rising, falling, or either
// - Compare actions: none, toggle, clear, set
// - Toggle-on-overflow acts only in compare mode
// - Overflow beats compare in same cycle
// - Max-duty with overflow toggle set forces full duty from next period
// - Value registers hold capture or compare value
// - High-byte read blocks captures until low read
// - High-byte write blocks compares until low write
// - Halt with clear leaves counter at zero
//
// Our own choice: strobed register access.
`default_nettype none

module tcc_capture_compare (
    input wire logic clk,
    input wire logic reset_n,
    input wire tcc_pkg::tcc_addr_t addr,
    input wire tcc_pkg::tcc_byte_t wdata,
    input wire logic wr,
    input wire logic rd,
    input wire tcc_pkg::tcc_word_t cnt_value,
    input wire logic cnt_overflow,
    input wire logic [1:0] chan_pin_in,
    output tcc_pkg::tcc_byte_t rdata_ff,
    output logic [1:0] chan_pin_out_ff,
    output logic [1:0] chan_pin_oe_ff,
    output logic [1:0] irq_ff,
    output logic counter_halt_ff,
    output logic counter_clear_ff
);
    import tcc_pkg::*;

    // ********************************************************
    // Address decoding
    // ********************************************************
    function automatic logic reg_hit(input tcc_addr_t a, input tcc_addr_t o);
        reg_hit = (a == o);
    endfunction

    logic [1:0] sel_sc;
    logic [1:0] sel_hi;
    logic [1:0] sel_lo;
    logic sel_ctl;
    assign sel_ctl = reg_hit(addr, OFF_CTL);
    assign sel_sc = {reg_hit(addr, OFF_SC1), reg_hit(addr, OFF_SC0)};
    assign sel_hi = {reg_hit(addr, OFF_VAL1_HI), reg_hit(addr, OFF_VAL0_HI)};
    assign sel_lo = {reg_hit(addr, OFF_VAL1_LO), reg_hit(addr, OFF_VAL0_LO)};

    // ********************************************************
    // Channel state and shared signals
    // ********************************************************
    tcc_chan_cfg_t cfg_ff [2];
    tcc_word_t value [2];
    tcc_word_t cmp_val [2];
    logic [1:0] flag_ff, arm_ff, cap_inh_ff, cmp_inh_ff;
    logic [1:0] sync1_ff, sync2_ff, sync3_ff, level_ff;
    logic [1:0] match_prev_ff, max_eff_ff, pin_ff;
    logic [1:0] cap_mode, cmp_mode, cap_fire, cmp_hit, ovf_act, event_hit;
    logic [1:0] match, edge_rise, edge_fall, chan_off, clr_ok;
    logic [1:0] wr_hi, wr_lo, cap_en;
    logic last_wr_ff, active_ff;
    logic ch1_off;

    // channel 0 buffered bit takes channel 1 away
    assign ch1_off = cfg_ff[0].buffered_mode_select;
    assign chan_off = {ch1_off, 1'b0};

    // Buffered compare reads whichever register was latched at overflow
    assign cmp_val[0] = (ch1_off && active_ff) ? value[1] : value[0];
    assign cmp_val[1] = value[1];

    // ********************************************************
    // Value registers
    // ********************************************************
    assign wr_hi = sel_hi & {2{wr}};
    assign wr_lo = sel_lo & {2{wr}};
    assign cap_en = cap_fire;

    tcc_value_store u_store (
        .clk(clk),
        .wr_hi(wr_hi),
        .wr_lo(wr_lo),
        .wdata(wdata),
        .cap_en(cap_en),
        .cap_data(cnt_value),
        .value_ff(value)
    );

    // ********************************************************
    // Per-channel logic
    // ********************************************************
    for (genvar gi = 0; gi < NUM_CH; gi++) begin : g_ch
        logic [1:0] els;
        logic msa, is_buf, tov;
        assign els = cfg_ff[gi].edge_level_sel;
        assign msa = cfg_ff[gi].mode_select_a;
        assign is_buf = cfg_ff[gi].buffered_mode_select;
        assign tov = cfg_ff[gi].toggle_on_overflow;

        // Mode decode; buffered mode ignores bit A
        assign cap_mode[gi] = !chan_off[gi] && !is_buf && !msa
            && (els != ELS_OFF);
        assign cmp_mode[gi] = !chan_off[gi] && (is_buf || msa);

        // Filtered edges: a change counts once stages two and three agree
        assign edge_rise[gi] = (sync2_ff[gi] == sync3_ff[gi])
            && sync3_ff[gi] && !level_ff[gi];
        assign edge_fall[gi] = (sync2_ff[gi] == sync3_ff[gi])
            && !sync3_ff[gi] && level_ff[gi];

        // Captures stop while the counter is halted or the pair is locked
        assign cap_fire[gi] = cap_mode[gi] && !cap_inh_ff[gi]
            && !counter_halt_ff
            && ((els[0] && edge_rise[gi])
            || (els[1] && edge_fall[gi]));

        // Fire once on entry to a match; counter may dwell on a value
        assign match[gi] = (cnt_value == cmp_val[gi]);
        assign cmp_hit[gi] = cmp_mode[gi] && !cmp_inh_ff[gi]
            && match[gi] && !match_prev_ff[gi];
        assign ovf_act[gi] = cmp_mode[gi] && tov && cnt_overflow;
        assign event_hit[gi] = cap_fire[gi] || cmp_hit[gi];

        // Clear only if armed by an earlier read and no new event now
        assign clr_ok[gi] = wr && sel_sc[gi] && !wdata[SC_FLAG_BIT]
            && arm_ff[gi] && !chan_off[gi];

        // Configuration and flag
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                cfg_ff[gi] <= CFG_RESET;
                flag_ff[gi] <= 1'b0;
                arm_ff[gi] <= 1'b0;
            end else begin
                if (wr && sel_sc[gi] && !chan_off[gi]) begin
                    cfg_ff[gi] <= tcc_chan_cfg_t'(wdata[SC_FLAG_BIT-1:0]);
                    if (gi != 0) begin
                        cfg_ff[gi].buffered_mode_select <= 1'b0;
                    end
                end
                flag_ff[gi] <= event_hit[gi] || (flag_ff[gi] && !clr_ok[gi]);
                arm_ff[gi] <= !event_hit[gi] && !(wr && sel_sc[gi])
                    && (arm_ff[gi] || (rd && sel_sc[gi] && flag_ff[gi]));
            end
        end

        // Byte-pair locks
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                cap_inh_ff[gi] <= 1'b0;
                cmp_inh_ff[gi] <= 1'b0;
            end else begin
                if (rd && sel_lo[gi]) begin
                    cap_inh_ff[gi] <= 1'b0;
                end else if (rd && sel_hi[gi] && cap_mode[gi]) begin
                    cap_inh_ff[gi] <= 1'b1;
                end
                if (wr && sel_lo[gi]) begin
                    cmp_inh_ff[gi] <= 1'b0;
                end else if (wr && sel_hi[gi] && cmp_mode[gi]) begin
                    cmp_inh_ff[gi] <= 1'b1;
                end
            end
        end

        // Pin synchroniser, three stages
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                sync1_ff[gi] <= 1'b0;
                sync2_ff[gi] <= 1'b0;
                sync3_ff[gi] <= 1'b0;
                level_ff[gi] <= 1'b0;
                match_prev_ff[gi] <= 1'b0;
            end else begin
                sync1_ff[gi] <= chan_pin_in[gi];
                sync2_ff[gi] <= sync1_ff[gi];
                sync3_ff[gi] <= sync2_ff[gi];
                if (sync2_ff[gi] == sync3_ff[gi]) begin
                    level_ff[gi] <= sync3_ff[gi];
                end
                match_prev_ff[gi] <= match[gi];
            end
        end

        // Pin level: preset, max duty, overflow, then compare action
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                pin_ff[gi] <= 1'b1;
                max_eff_ff[gi] <= 1'b0;
            end else begin
                if (cnt_overflow) begin
                    max_eff_ff[gi] <= tov
                        && cfg_ff[gi].max_duty_force;
                end
                if (els == ELS_OFF) begin
                    pin_ff[gi] <= !msa;
                end else if (cmp_mode[gi] && max_eff_ff[gi]) begin
                    pin_ff[gi] <= 1'b1;
                end else if (ovf_act[gi]) begin
                    pin_ff[gi] <= !pin_ff[gi];
                end else if (cmp_hit[gi]) begin
                    case (els)
                        ELS_TOGGLE: pin_ff[gi] <= !pin_ff[gi];
                        ELS_CLEAR: pin_ff[gi] <= 1'b0;
                        default: pin_ff[gi] <= 1'b1;
                    endcase
                end
            end
        end

        // Outputs; drive only in a compare mode with a nonzero field
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                chan_pin_out_ff[gi] <= 1'b1;
                chan_pin_oe_ff[gi] <= 1'b0;
                irq_ff[gi] <= 1'b0;
            end else begin
                chan_pin_out_ff[gi] <= pin_ff[gi];
                chan_pin_oe_ff[gi] <= cmp_mode[gi]
                    && (els != ELS_OFF);
                irq_ff[gi] <= flag_ff[gi] && cfg_ff[gi].irq_enable
                    && !chan_off[gi];
            end
        end
    end

    // ********************************************************
    // Buffer pair selection and counter control
    // ********************************************************
    // Switch compare source only at overflow so a period is never split
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            last_wr_ff <= 1'b0;
            active_ff <= 1'b0;
        end else begin
            if (wr_lo[1]) begin
                last_wr_ff <= 1'b1;
            end else if (wr_lo[0]) begin
                last_wr_ff <= 1'b0;
            end
            if (cnt_overflow) begin
                active_ff <= last_wr_ff;
            end
        end
    end

    // Clear pulse with halt held keeps the outside counter at zero
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            counter_halt_ff <= HALT_RESET;
            counter_clear_ff <= 1'b0;
        end else begin
            if (wr && sel_ctl) begin
                counter_halt_ff <= wdata[CTL_HALT_BIT];
            end
            counter_clear_ff <= wr && sel_ctl && wdata[CTL_CLEAR_BIT];
        end
    end

    // ********************************************************
    // Read data
    // ********************************************************
    tcc_byte_t sc_byte [2];
    tcc_byte_t rd_mux;
    assign sc_byte[0] = {flag_ff[0], cfg_ff[0]};
    assign sc_byte[1] = ch1_off ? ZERO_BYTE : {flag_ff[1], cfg_ff[1]};

    // Unmapped addresses read as zero
    assign rd_mux = sel_ctl ? tcc_byte_t'(counter_halt_ff) << CTL_HALT_BIT
        : sel_sc[0] ? sc_byte[0]
        : sel_sc[1] ? sc_byte[1]
        : sel_hi[0] ? value[0][CNT_W-1:DATA_W]
        : sel_lo[0] ? value[0][DATA_W-1:0]
        : sel_hi[1] ? value[1][CNT_W-1:DATA_W]
        : sel_lo[1] ? value[1][DATA_W-1:0]
        : ZERO_BYTE;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata_ff <= ZERO_BYTE;
        end else if (rd) begin
            rdata_ff <= rd_mux;
        end
    end

    // ********************************************************
    // Assertions on channel 0, reset of both channels, the channel 1 shut-off and shared logic
    // ********************************************************
    property p_flag_event;
        @(posedge clk) disable iff (!reset_n)
        event_hit[0] |=> flag_ff[0];
    endproperty
    a_flag_event: assert property (p_flag_event)
        else $error("flag not set after event");

    property p_clear_needs_arm;
        @(posedge clk) disable iff (!reset_n)
        (flag_ff[0] && !arm_ff[0] && wr && sel_sc[0]) |=> flag_ff[0];
    endproperty
    a_clear_needs_arm: assert property (p_clear_needs_arm)
        else $error("flag cleared without prior read");

    property p_reset_clears;
        @(posedge clk) !reset_n |=> (flag_ff == 2'h0)
            && (cfg_ff[0] == CFG_RESET) && (cfg_ff[1] == CFG_RESET);
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("reset left flag or config set");

    property p_irq_gate;
        @(posedge clk) disable iff (!reset_n)
        !cfg_ff[0].irq_enable |=> !irq_ff[0];
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt while disabled");

    property p_irq_follow;
        @(posedge clk) disable iff (!reset_n)
        (flag_ff[0] && cfg_ff[0].irq_enable) [*2] |-> irq_ff[0];
    endproperty
    a_irq_follow: assert property (p_irq_follow)
        else $error("interrupt missing with flag and enable");

    property p_ch1_released;
        @(posedge clk) disable iff (!reset_n)
        ch1_off [*2] |-> !chan_pin_oe_ff[1] && !irq_ff[1];
    endproperty
    a_ch1_released: assert property (p_ch1_released)
        else $error("channel 1 active in buffered mode");

    property p_preset;
        @(posedge clk) disable iff (!reset_n)
        (cfg_ff[0].edge_level_sel == ELS_OFF) |=>
            pin_ff[0] == !$past(cfg_ff[0].mode_select_a);
    endproperty
    a_preset: assert property (p_preset)
        else $error("preset level wrong");

    property p_ovf_wins;
        @(posedge clk) disable iff (!reset_n)
        (ovf_act[0] && cmp_hit[0] && !max_eff_ff[0]
            && cfg_ff[0].edge_level_sel != ELS_OFF)
            |=> pin_ff[0] != $past(pin_ff[0]);
    endproperty
    a_ovf_wins: assert property (p_ovf_wins)
        else $error("overflow toggle lost to compare");

    property p_cap_lock;
        @(posedge clk) disable iff (!reset_n)
        cap_inh_ff[0] |-> !cap_fire[0];
    endproperty
    a_cap_lock: assert property (p_cap_lock)
        else $error("capture while high byte locked");

    property p_cmp_lock;
        @(posedge clk) disable iff (!reset_n)
        (wr && sel_hi[0] && cmp_mode[0]) ##1 (!(wr && sel_lo[0])) [*2]
            |-> !cmp_hit[0];
    endproperty
    a_cmp_lock: assert property (p_cmp_lock)
        else $error("compare while high byte pending");

    property p_halt_clear;
        @(posedge clk) disable iff (!reset_n)
        (wr && sel_ctl && wdata[CTL_HALT_BIT] && wdata[CTL_CLEAR_BIT])
            |=> counter_halt_ff && counter_clear_ff ##1 !counter_clear_ff;
    endproperty
    a_halt_clear: assert property (p_halt_clear)
        else $error("halt with clear not applied");

    c_capture: cover property (@(posedge clk) disable iff (!reset_n)
        cap_fire[0]);
    c_compare: cover property (@(posedge clk) disable iff (!reset_n)
        cmp_hit[0] && chan_pin_oe_ff[0]);
    c_buffered: cover property (@(posedge clk) disable iff (!reset_n)
        ch1_off && cmp_hit[0] && active_ff);
    c_max_duty: cover property (@(posedge clk) disable iff (!reset_n)
        max_eff_ff[0] && cmp_mode[0]);

endmodule

`default_nettype wire

/* tb/tcc_far_model.sv */
// Far-side model: the shared timer counter and the outside pin sources.
// Assumes halt and clear come from the block, all on one clock.
`default_nettype none
module tcc_far_model #(
    parameter tcc_pkg::tcc_word_t MOD_VAL = 16'h0040
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic counter_halt,
    input wire logic counter_clear,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe,
    input wire logic [1:0] ext_level,
    output tcc_pkg::tcc_word_t cnt_value,
    output logic cnt_overflow,
    output logic [1:0] chan_pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import tcc_pkg::*;

    // ****************************************
    // Counter and pin wires
    // ****************************************

    // A halted counter never overflows
    assign cnt_overflow = !counter_halt && (cnt_value == MOD_VAL);

    // Clear wins over halt, so halt plus clear parks it at zero
    always_ff @(posedge clk) begin
        if (!reset_n || counter_clear || cnt_overflow) begin
            cnt_value <= 16'h0000;
        end else if (!counter_halt) begin
            cnt_value <= cnt_value + 16'h0001;
        end
    end

    // Block drives the wire while enabled, else the outside source does
    assign chan_pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

/* tb/tcc_capture_compare_tb.sv */
// Bench: drives the capture/compare block and checks it against a model.
// Assumes the far-side model supplies the counter and pin levels on clk.
`default_nettype none
module tcc_capture_compare_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tcc_pkg::*;
    localparam tcc_word_t MOD_VAL = 16'h0040;
    logic clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0;
    tcc_addr_t addr = 8'h00;
    tcc_byte_t wdata = 8'h00, rdata_ff, rv;
    tcc_word_t cnt_value, tgt;
    logic [1:0] ext_level = 2'b00, chan_pin_in, pin_out, pin_oe, irq;
    logic cnt_overflow, halt, clr, prev;
    int n_errors = 0, num_checks = 0;
    int exp_cfg [2] = '{0, 0};
    int exp_flag [2] = '{0, 0};
    logic [31:0] rng = 32'h58C5896E;
    tcc_addr_t ra [4] = '{OFF_CTL, OFF_SC0, OFF_SC1, 8'h50};
    tcc_byte_t rx [4] = '{8'h20, 8'h00, 8'h00, 8'h00};

    // 50 MHz bench clock
    always #10 clk = ~clk;

    tcc_capture_compare dut (.clk, .reset_n, .addr, .wdata, .wr, .rd,
        .cnt_value, .cnt_overflow, .chan_pin_in, .rdata_ff,
        .chan_pin_out_ff(pin_out), .chan_pin_oe_ff(pin_oe), .irq_ff(irq),
        .counter_halt_ff(halt), .counter_clear_ff(clr));
    tcc_far_model #(.MOD_VAL(MOD_VAL)) far (.clk, .reset_n,
        .counter_halt(halt), .counter_clear(clr), .pin_out, .pin_oe,
        .ext_level, .cnt_value, .cnt_overflow, .chan_pin_in);

    // ****************************************
    // Helpers
    // ****************************************

    // Fixed-seed xorshift
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic check(input string what, input logic [15:0] exp,
            input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Strobes last one cycle; master moves only after an edge
    task automatic wr_reg(input tcc_addr_t a, input tcc_byte_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand from the cycle after the strobe until the next read
    task automatic rd_reg(input tcc_addr_t a, output tcc_byte_t d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata_ff;
    endtask

    // Model of the status byte; channel 1 has no buffered bit
    task automatic set_sc(input int ch, input tcc_byte_t d);
        wr_reg(ch ? OFF_SC1 : OFF_SC0, d);
        exp_cfg[ch] = int'(d & (ch ? 8'h5F : 8'h7F));
    endtask

    task automatic chk_sc(input int ch);
        rd_reg(ch ? OFF_SC1 : OFF_SC0, rv);
        check("status", 16'(exp_flag[ch] * 128 + exp_cfg[ch]), 16'(rv));
    endtask

    // Read with the flag set arms it, the zero write then clears
    task automatic clr_flag(input int ch);
        chk_sc(ch);
        set_sc(ch, 8'(exp_cfg[ch]));
        exp_flag[ch] = 0;
        chk_sc(ch);
    endtask

    // Bounded wait for a counter value, always at least one edge
    task automatic wait_cnt(input tcc_word_t v);
        @(posedge clk);
        #1;
        for (int i = 0; i < 300 && cnt_value !== v; i++) begin
            @(posedge clk);
            #1;
        end
        check("count", v, cnt_value);
    endtask

    // Mode changes only with the counter halted and cleared
    task automatic setup(input int ch, input tcc_byte_t sc,
            input tcc_word_t v);
        wr_reg(OFF_CTL, 8'h30);
        repeat (2) @(posedge clk);
        #1;
        check("cnt_clear", 16'h0000, cnt_value);
        set_sc(ch, sc);
        wr_reg(ch ? OFF_VAL1_HI : OFF_VAL0_HI, v[15:8]);
        wr_reg(ch ? OFF_VAL1_LO : OFF_VAL0_LO, v[7:0]);
        wr_reg(OFF_CTL, 8'h00);
    endtask

    // Pin change early in a period, then room for sync and capture
    task automatic pin_edge(input logic lvl);
        wait_cnt(16'h0008);
        @(posedge clk);
        ext_level[1] <= lvl;
        repeat (10) @(posedge clk);
        #1;
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Sequence
    // ****************************************

    // Hang guard, far beyond the few thousand cycles expected
    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        $display("[FAIL] watchdog expected finish seen hang");
        give_verdict();
    end

    initial begin
        repeat (15) @(posedge clk);
        #1;
        check("oe_rst", 16'h0000, 16'(pin_oe));
        check("irq_rst", 16'h0000, 16'(irq));
        check("pin_rst", 16'h0003, 16'(pin_out));
        @(posedge clk);
        reset_n <= 1'b1;
        // Reset values, an unmapped read, random config readback
        for (int i = 0; i < 4; i++) begin
            rd_reg(ra[i], rv);
            check("reg_rst", 16'(rx[i]), 16'(rv));
        end
        // Value pairs power up unknown; park them off the halted zero count
        // so a random compare mode cannot turn the flag unknown
        wr_reg(OFF_VAL1_HI, 8'hFF);
        wr_reg(OFF_VAL1_LO, 8'hFF);
        wr_reg(OFF_VAL0_HI, 8'hFF);
        wr_reg(OFF_VAL0_LO, 8'hFF);
        rd_reg(OFF_VAL1_HI, rv);
        check("val_rw", 16'h00FF, 16'(rv));
        for (int i = 0; i < 4; i++) begin
            rng = xs(rng);
            set_sc(1, rng[7:0]);
            chk_sc(1);
        end
        // Capture on channel 1 with overflow toggle set, which is inert
        for (int code = 1; code < 4; code++) begin
            setup(1, 8'(code * 4 + 2), 16'h0000);
            for (int e = 0; e < 2; e++) begin
                pin_edge(e == 0);
                exp_flag[1] = (code >> e) & 1;
                check("cap_oe", 16'h0000, 16'(pin_oe[1]));
                chk_sc(1);
                if (exp_flag[1] != 0) begin
                    rd_reg(OFF_VAL1_HI, rv);
                    tgt[15:8] = rv;
                    rd_reg(OFF_VAL1_LO, rv);
                    tgt[7:0] = rv;
                    prev = tgt > 16'h0009 && tgt < 16'h0011;
                    check("cap_val", 16'h0001, 16'(prev));
                    clr_flag(1);
                end
            end
        end
        // High-byte read holds captures off until the low byte is read
        rd_reg(OFF_VAL1_HI, rv);
        pin_edge(1'b1);
        chk_sc(1);
        rd_reg(OFF_VAL1_LO, rv);
        pin_edge(1'b0);
        exp_flag[1] = 1;
        chk_sc(1);
        // Compare: unbuffered codes 00 to 11, then buffered 01 to 11
        for (int mb = 0; mb < 2; mb++) begin
            for (int code = mb; code < 4; code++) begin
                rng = xs(rng);
                tgt = 16'h0008 + 16'(rng[4:0]);
                setup(0, 8'(mb * 32 + 16 + code * 4 + code % 2 * 64), tgt);
                wait_cnt(MOD_VAL);
                wait_cnt(tgt);
                prev = (code == 1) ? !pin_out[0] : (code == 3);
                repeat (4) @(posedge clk);
                #1;
                exp_flag[0] = 1;
                check("oe", 16'(code != 0), 16'(pin_oe[0]));
                check("pin", 16'(prev), 16'(pin_out[0]));
                check("irq", 16'(code % 2), 16'(irq[0]));
                clr_flag(0);
                check("irq_off", 16'h0000, 16'(irq[0]));
            end
        end
        // Buffered channel 0 shuts channel 1 out
        wr_reg(OFF_SC1, 8'h5C);
        rd_reg(OFF_SC1, rv);
        check("ch1_off", 16'h0000, {rv, 7'h00, pin_oe[1]});
        // Half-written compare value holds off the match
        setup(0, 8'h5C, 16'h0020);
        wait_cnt(16'h0024);
        exp_flag[0] = 1;
        clr_flag(0);
        wr_reg(OFF_VAL0_HI, 8'h00);
        wait_cnt(MOD_VAL);
        wait_cnt(16'h0024);
        chk_sc(0);
        wr_reg(OFF_VAL0_LO, 8'h20);
        wait_cnt(16'h0024);
        exp_flag[0] = 1;
        chk_sc(0);
        // Overflow toggle beats a same-cycle clear, then max duty
        setup(0, 8'h1A, MOD_VAL);
        for (int k = 0; k < 5; k++) begin
            if (k == 2) begin
                set_sc(0, 8'h1B);
            end
            wait_cnt(MOD_VAL);
            repeat (4) @(posedge clk);
            #1;
            if (k == 1 || k > 2) begin
                check("ovf_pin", 16'(k == 1 ? !prev : 1'b1),
                    16'(pin_out[0]));
            end
            prev = pin_out[0];
        end
        give_verdict();
    end
endmodule
`default_nettype wire
